// file: stc_pkg.sv
/*
  Shared constants, field layout and decode helpers for the SYSREF timing
  calibration block. Assumes a single 125 MHz device-side clock domain and
  register indices that are four bytes apart on an APB bus.
*/
package stc_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [9:0] STC_IDX_ENABLE   = 10'h2b0;
  localparam logic [9:0] STC_IDX_CONFIG   = 10'h2b1;
  localparam logic [9:0] STC_IDX_STATUS   = 10'h2b2;
  localparam logic [9:0] STC_IDX_DELAY    = 10'h2b5;
  localparam logic [9:0] STC_IDX_INT_STAT = 10'h2b9;
  localparam logic [9:0] STC_IDX_INT_EN   = 10'h2ba;
  localparam logic [9:0] STC_IDX_INT_CLR  = 10'h2bb;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [7:0]  STC_ENABLE_RST = 8'h00;
  localparam logic [7:0]  STC_CONFIG_RST = 8'h05;
  localparam logic [23:0] STC_DELAY_RST  = 24'h000000;
  localparam int          STC_EN_BIT     = 0;
  localparam int          STC_AVG_LSB    = 2;
  localparam int          STC_HDUR_LSB   = 0;
  localparam int          STC_DONE_BIT   = 17;
  localparam int          STC_INV_BIT    = 16;
  localparam int          STC_INT_DONE   = 0;
  localparam int          STC_INT_FAIL   = 1;

  // ----------------------------------------
  // Timing figures in device-clock cycles
  // ----------------------------------------
  localparam logic [15:0] STC_LIMIT_0    = 16'd85;
  localparam logic [15:0] STC_LIMIT_1    = 16'd1100;
  localparam logic [15:0] STC_LIMIT_2    = 16'd5200;
  localparam logic [15:0] STC_LIMIT_3    = 16'd21580;
  localparam logic [31:0] STC_BOUND_BASE = 32'd256 * 32'd19;
  localparam logic [8:0]  STC_POW4_BASE  = 9'h004;

  typedef enum logic [1:0] {
    STC_IDLE = 2'b00,
    STC_RUN  = 2'b01,
    STC_DONE = 2'b11,
    STC_FAIL = 2'b10
  } stc_state_t;

  // 4, 16, 64, 256 for codes 0..3 (averages and accumulation length)
  function automatic logic [8:0] stc_pow4(input logic [1:0] code);
    stc_pow4 = STC_POW4_BASE << {code, 1'b0};
  endfunction : stc_pow4

  function automatic logic [15:0] stc_limit(input logic [1:0] code);
    unique case (code)
      2'h0: stc_limit = STC_LIMIT_0;
      2'h1: stc_limit = STC_LIMIT_1;
      2'h2: stc_limit = STC_LIMIT_2;
      2'h3: stc_limit = STC_LIMIT_3;
    endcase
  endfunction : stc_limit

  function automatic logic [31:0] stc_bound(input logic [1:0] avg, input logic [1:0] hdur);
    logic [3:0] e;
    e = {2'h0, avg} + {2'h0, hdur} + 4'h2;
    stc_bound = STC_BOUND_BASE << {e, 1'b0};
  endfunction : stc_bound

endpackage : stc_pkg

// file: stc_accumulator.sv
/*
  One high-speed accumulation: counts the cycles in which the synchronised
  timing reference is high over a window of 4, 16, 64 or 256 cycles.
  Assumes start_i is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
module stc_accumulator import stc_pkg::*; (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       start_i,
  input  wire logic [1:0] len_code_i,
  input  wire logic       sysref_i,
  output logic            done_o,
  output logic [8:0]      hits_o
);

  typedef struct packed {
    logic       busy;
    logic [8:0] cyc;
    logic [8:0] hits;
    logic       done;
    logic [8:0] result;
  } stc_acc_t;

  stc_acc_t s_q;
  stc_acc_t s_d;
  logic [8:0] last_cyc;

  // ----------------------------------------
  // Window counter
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    last_cyc = stc_pow4(len_code_i) - 9'h001;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.busy = 1'b1;
      s_d.cyc  = '0;
      s_d.hits = '0;
    end else if (s_q.busy) begin
      s_d.hits = s_q.hits + {8'h00, sysref_i};
      s_d.cyc  = s_q.cyc + 9'h001;
      if (s_q.cyc == last_cyc) begin // R2
        s_d.busy   = 1'b0;
        s_d.done   = 1'b1;
        s_d.result = s_q.hits + {8'h00, sysref_i};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
  assign hits_o = s_q.result;

  a_window_length: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    done_o |-> $past(s_q.cyc) == stc_pow4(len_code_i) - 9'h001)
    else $error("Accumulation window length wrong");

endmodule : stc_accumulator

// file: stc_calibrator.sv
/*
  SYSREF timing calibration engine with its APB register file: enable,
  configuration, status, manual aperture delay and interrupt registers.
  Assumes an APB master on ref_clk and a SYSREF pin from outside the domain.
*/
// Function
// [R1] Averaging code selects 4/16/64/256 averages
// [R2] Length code selects 4/16/64/256 cycle windows
// [R3] Period above code limit fails the calibration
// [R4] Sequence ends within the documented cycle bound
// [R5] Complete flag only while enabled and finished
// [R6] Status low bits hold computed delay
// [R7] Status is read-only 24 bits, top reserved
// [R8] Manual delay register read-write, reset zero
// [R9] Enable rising edge starts calibration
// [R10] Enabled: automatic delay; disabled: manual delay
// [R11] Software configures first, converter calibration idle
// [R12] Manual bit 16 inverts the device clock
// [R13] Finished result drives the effective delay
`timescale 1ns/1ps
module stc_calibrator import stc_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sysref_pin,
  output logic      [16:0] aperture_delay_setting,
  output logic             invert_device_clock,
  output logic             calibration_complete,
  output logic             irq
);

  typedef struct packed {
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
    logic [7:0] enable;
    logic       enable_prev;
    logic [7:0] cal_config;
    logic [23:0] delay_reg;
    logic [1:0] int_stat;
    logic [1:0] int_en;
    logic       irq;
    logic       sync1;
    logic       sync2;
    logic       sr_prev;
    stc_state_t state;
    logic [1:0] avg_code;
    logic [1:0] len_code;
    logic [8:0] avg_cnt;
    logic [16:0] sum;
    logic [16:0] result;
    logic [15:0] per_cnt;
    logic       acc_start;
    logic [16:0] delay_out;
    logic       invert;
    logic       complete;
  } stc_regs_t;

  stc_regs_t  r_q;
  stc_regs_t  r_d;
  logic       acc_done;
  logic [8:0] acc_hits;
  logic [9:0] idx;
  logic       hit;
  logic       wr_end;
  logic [1:0] clr;
  logic [1:0] events;
  logic [16:0] new_sum;

  // Unmapped indices answer with an error and take no write
  function automatic logic stc_mapped(input logic [9:0] i);
    stc_mapped = (i == STC_IDX_ENABLE) || (i == STC_IDX_CONFIG) ||
                 (i == STC_IDX_STATUS) || (i == STC_IDX_DELAY) ||
                 (i == STC_IDX_INT_STAT) || (i == STC_IDX_INT_EN) ||
                 (i == STC_IDX_INT_CLR);
  endfunction : stc_mapped

  stc_accumulator u_acc (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .start_i    (r_q.acc_start),
    .len_code_i (r_q.len_code),
    .sysref_i   (r_q.sync2),
    .done_o     (acc_done),
    .hits_o     (acc_hits)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    idx = paddr[11:2];
    hit = stc_mapped(idx);
    wr_end = psel && penable && r_q.pready && pwrite && hit;
    clr = '0;
    events = '0;
    new_sum = r_q.sum + {8'h00, acc_hits};

    // Pin synchroniser; only sync2 feeds logic
    r_d.sync1 = sysref_pin;
    r_d.sync2 = r_q.sync1;
    r_d.sr_prev = r_q.sync2;

    // APB: answer in the first cycle of the access phase, no wait states
    r_d.pready = 1'b0;
    if (psel && !penable) begin
      r_d.pready  = 1'b1;
      r_d.pslverr = !hit;
      r_d.prdata  = '0;
      if (idx == STC_IDX_ENABLE) begin
        r_d.prdata = {24'h000000, r_q.enable};
      end else if (idx == STC_IDX_CONFIG) begin
        r_d.prdata = {24'h000000, r_q.cal_config};
      end else if (idx == STC_IDX_STATUS) begin // R7
        r_d.prdata = {8'h00, 6'h00, r_q.complete, r_q.result}; // R6
      end else if (idx == STC_IDX_DELAY) begin
        r_d.prdata = {8'h00, r_q.delay_reg};
      end else if (idx == STC_IDX_INT_STAT) begin
        r_d.prdata = {30'h00000000, r_q.int_stat};
      end else if (idx == STC_IDX_INT_EN) begin
        r_d.prdata = {30'h00000000, r_q.int_en};
      end
    end

    // Register writes; the status index takes no write
    if (wr_end) begin
      if (idx == STC_IDX_ENABLE) begin
        r_d.enable = pwdata[7:0];
      end else if (idx == STC_IDX_CONFIG) begin
        r_d.cal_config = pwdata[7:0];
      end else if (idx == STC_IDX_DELAY) begin
        r_d.delay_reg = pwdata[23:0]; // R8
      end else if (idx == STC_IDX_INT_EN) begin
        r_d.int_en = pwdata[1:0];
      end else if (idx == STC_IDX_INT_CLR) begin
        clr = pwdata[1:0];
      end
    end

    // ----------------------------------------
    // Calibration sequencer
    // ----------------------------------------
    r_d.enable_prev = r_q.enable[STC_EN_BIT];
    r_d.acc_start = 1'b0;
    // Saturate so a missing reference cannot wrap back under the limit
    if (r_q.sync2 && !r_q.sr_prev) begin
      r_d.per_cnt = '0;
    end else if (r_q.per_cnt != 16'hffff) begin
      r_d.per_cnt = r_q.per_cnt + 16'h0001;
    end

    if (!r_q.enable[STC_EN_BIT]) begin
      r_d.state = STC_IDLE;
    end else if (!r_q.enable_prev) begin // R9
      // Config is latched here, so later writes cannot upset a run
      r_d.state     = STC_RUN;
      r_d.avg_code  = r_q.cal_config[STC_AVG_LSB +: 2];
      r_d.len_code  = r_q.cal_config[STC_HDUR_LSB +: 2];
      r_d.avg_cnt   = '0;
      r_d.sum       = '0;
      r_d.per_cnt   = '0;
      r_d.acc_start = 1'b1;
    end else begin
      unique case (r_q.state)
        STC_IDLE: begin
        end
        STC_RUN: begin
          if (r_q.per_cnt > stc_limit(r_q.len_code)) begin // R3
            r_d.state = STC_FAIL;
            events[STC_INT_FAIL] = 1'b1;
          end else if (acc_done) begin
            r_d.sum     = new_sum;
            r_d.avg_cnt = r_q.avg_cnt + 9'h001;
            if (r_q.avg_cnt + 9'h001 == stc_pow4(r_q.avg_code)) begin // R1
              r_d.state  = STC_DONE;
              r_d.result = new_sum;
              events[STC_INT_DONE] = 1'b1;
            end else begin
              r_d.acc_start = 1'b1;
            end
          end
        end
        STC_DONE: begin
        end
        STC_FAIL: begin
        end
      endcase
    end

    r_d.complete = r_q.enable[STC_EN_BIT] && (r_d.state == STC_DONE); // R5

    // ----------------------------------------
    // Effective delay
    // ----------------------------------------
    // Mid-run the output holds; manual writes are ignored while enabled
    if (!r_q.enable[STC_EN_BIT]) begin
      r_d.delay_out = r_q.delay_reg[16:0]; // R10
    end else if (r_q.state == STC_DONE) begin
      r_d.delay_out = r_q.result; // R13
    end
    r_d.invert = r_d.delay_out[STC_INV_BIT]; // R12

    // Set wins over a clear in the same cycle
    r_d.int_stat = (r_q.int_stat & ~clr) | events;
    r_d.irq = |(r_d.int_stat & r_q.int_en);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r_q           <= '0;
      r_q.state     <= STC_IDLE;
      r_q.enable    <= STC_ENABLE_RST;
      r_q.cal_config <= STC_CONFIG_RST;
      r_q.delay_reg <= STC_DELAY_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata                 = r_q.prdata;
  assign pready                 = r_q.pready;
  assign pslverr                = r_q.pslverr;
  assign aperture_delay_setting = r_q.delay_out;
  assign invert_device_clock    = r_q.invert;
  assign calibration_complete   = r_q.complete;
  assign irq                    = r_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] run_cycles_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || r_q.state != STC_RUN) begin
      run_cycles_q <= '0;
    end else begin
      run_cycles_q <= run_cycles_q + 32'h00000001;
    end
  end

  a_avg_count: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    $rose(r_q.state == STC_DONE) |-> r_q.avg_cnt == stc_pow4(r_q.avg_code))
    else $error("Average count differs from selection");
  a_period_fail: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    (r_q.state == STC_RUN && r_q.enable_prev && r_q.enable[STC_EN_BIT] &&
     r_q.per_cnt > stc_limit(r_q.len_code)) |=> r_q.state == STC_FAIL)
    else $error("Overlong reference period not failed");
  a_cal_bound: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
    r_q.state == STC_RUN |-> run_cycles_q < stc_bound(r_q.avg_code, r_q.len_code))
    else $error("Calibration exceeded its cycle bound");
  a_done_flag: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    r_q.complete |-> r_q.enable_prev && r_q.state == STC_DONE)
    else $error("Complete flag without enabled finished run");
  a_result_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    (r_q.state == STC_DONE) ##1 (r_q.state == STC_DONE) |-> $stable(r_q.result))
    else $error("Result changed after completion");
  a_status_ro: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
    (psel && !penable && !pwrite && paddr[11:2] == STC_IDX_STATUS) |=>
      pready && prdata[31:18] == 14'h0000)
    else $error("Status reserved bits not zero");
  a_delay_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
    (psel && penable && pready && pwrite && paddr[11:2] == STC_IDX_DELAY) |=>
      r_q.delay_reg == $past(pwdata[23:0]))
    else $error("Manual delay write lost");
  a_start_rise: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
    r_q.enable[STC_EN_BIT] && !r_q.enable_prev |=> r_q.state == STC_RUN ##1 r_q.acc_start == 1'b0)
    else $error("Enable edge did not start calibration");
  a_manual_path: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
    !r_q.enable[STC_EN_BIT] |=> aperture_delay_setting == $past(r_q.delay_reg[16:0]))
    else $error("Manual delay not applied");
  a_invert_clk: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
    !r_q.enable[STC_EN_BIT] ##1 !r_q.enable[STC_EN_BIT] |->
      invert_device_clock == $past(r_q.delay_reg[STC_INV_BIT]))
    else $error("Clock inversion not applied");
  a_auto_path: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
    r_q.enable[STC_EN_BIT] && r_q.state == STC_DONE |=> aperture_delay_setting == $past(r_q.result))
    else $error("Computed delay not applied");

  // Guards on manual and config writes, flag drop, sticky failure and computed inversion
  a_ignore_manual: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
    r_q.enable[STC_EN_BIT] && r_q.state != STC_DONE |=> $stable(aperture_delay_setting))
    else $error("Manual delay leaked into a run");
  a_complete_drop: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    !r_q.enable[STC_EN_BIT] |=> !calibration_complete)
    else $error("Complete flag outlived the enable");
  a_config_latch: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    r_q.state == STC_RUN ##1 r_q.state == STC_RUN |->
      $stable(r_q.avg_code) && $stable(r_q.len_code))
    else $error("Configuration changed during a run");
  a_fail_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    r_q.state == STC_FAIL && r_q.enable[STC_EN_BIT] |=> r_q.state == STC_FAIL)
    else $error("Failed calibration did not stay failed");
  a_auto_invert: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
    r_q.enable[STC_EN_BIT] && r_q.state == STC_DONE |=>
      invert_device_clock == $past(r_q.result[STC_INV_BIT]))
    else $error("Computed inversion not applied");

endmodule : stc_calibrator

// file: stc_sysref_src.sv
/*
  Behavioural system clock source making the SYSREF timing reference.
  Assumes the bench supplies the device clock and sets the half period.
*/
`timescale 1ns/1ps
module stc_sysref_src (
  input  wire logic       ref_clk,
  input  wire logic [7:0] half_period,
  output logic            sysref
);
  logic [7:0] cnt_q;

  initial begin
    sysref = 1'b0;
    cnt_q  = 8'h00;
  end

  // ----------------------------------------
  // Toggle generator
  // ----------------------------------------
  // Zero parks the line low: a run then sees no edges at all
  always @(posedge ref_clk) begin
    if (half_period == 8'h00) begin
      sysref <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (cnt_q + 8'h01 >= half_period) begin
      sysref <= ~sysref;
      cnt_q  <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : stc_sysref_src

// file: tb_sysref_timing_calibration.sv
/*
  Self-checking bench for the calibration block over APB.
  Assumes the sysref source model and the design package are compiled first.
*/
`timescale 1ns/1ps
module tb_sysref_timing_calibration import stc_pkg::*; ;
  logic        ref_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref_pin;
  logic [16:0] aperture_delay_setting;
  logic        invert_device_clock;
  logic        calibration_complete;
  logic        irq;
  logic [7:0]  half_period;
  int          n_fail;
  int          n_tests;

  stc_calibrator DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref_pin(sysref_pin),
    .aperture_delay_setting(aperture_delay_setting),
    .invert_device_clock(invert_device_clock),
    .calibration_complete(calibration_complete), .irq(irq));

  stc_sysref_src src (.ref_clk(ref_clk), .half_period(half_period), .sysref(sysref_pin));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t apb timeout", $time);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input string msg);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0, rd, err);
    chk(rd, exp, msg);
  endtask : rdc

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    logic        err;
    rdc(STC_IDX_CONFIG, 32'h05, "config reset");
    rdc(STC_IDX_DELAY, 32'h0, "delay reset");
    rdc(STC_IDX_ENABLE, 32'h0, "enable reset");
    apb(1'b0, 10'h2b8, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
  endtask : t_reset

  task automatic t_manual;
    wr(STC_IDX_DELAY, 32'hffff_ffff);
    rdc(STC_IDX_DELAY, 32'h00ff_ffff, "delay all ones");
    chk({15'h0, aperture_delay_setting}, 32'h1ffff, "manual delay");
    chk({31'h0, invert_device_clock}, 32'h1, "invert set");
    wr(STC_IDX_DELAY, 32'h0000_3c81);
    rdc(STC_IDX_DELAY, 32'h0000_3c81, "delay pattern");
    chk({15'h0, aperture_delay_setting}, 32'h03c81, "manual delay");
    chk({31'h0, invert_device_clock}, 32'h0, "invert clear");
  endtask : t_manual

  task automatic t_cal(input logic [1:0] a, input logic [1:0] h);
    int bound;
    int lim;
    int n;
    logic [31:0] res;
    // Toggling every cycle puts exactly half of any even window high
    res = ((32'd4 << (2 * a)) * (32'd4 << (2 * h))) / 2;
    bound = 256 * 19 * (1 << (2 * (a + h + 2)));
    lim = (bound < 20000) ? bound : 20000;
    half_period <= 8'h01;
    wr(STC_IDX_INT_EN, 32'h0);
    wr(STC_IDX_DELAY, 32'h0001_2345);
    wr(STC_IDX_ENABLE, 32'h0);
    wr(STC_IDX_CONFIG, {28'h0, a, h});
    wr(STC_IDX_ENABLE, 32'h1);
    n = 0;
    while (calibration_complete !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, calibration_complete}, 32'h1, "complete in bound");
    if (calibration_complete !== 1'b1) end_of_test();
    rdc(STC_IDX_STATUS, 32'h20000 | res, "status result");
    wr(STC_IDX_STATUS, 32'h0);
    rdc(STC_IDX_STATUS, 32'h20000 | res, "status read only");
    chk({15'h0, aperture_delay_setting}, res, "auto delay");
    wr(STC_IDX_DELAY, 32'h0000_0777);
    repeat (2) @(posedge ref_clk);
    chk({15'h0, aperture_delay_setting}, res, "manual ignored");
    chk({31'h0, irq}, 32'h0, "masked irq");
    rdc(STC_IDX_INT_STAT, 32'h1, "done event");
    wr(STC_IDX_INT_CLR, 32'h3);
    wr(STC_IDX_ENABLE, 32'h0);
    rdc(STC_IDX_INT_STAT, 32'h0, "event cleared");
    chk({31'h0, calibration_complete}, 32'h0, "complete drops");
    chk({15'h0, aperture_delay_setting}, 32'h00777, "manual back");
  endtask : t_cal

  task automatic t_fail;
    int n;
    half_period <= 8'h00;
    wr(STC_IDX_INT_EN, 32'h3);
    // Sixteen short windows outlast the 85-cycle limit
    wr(STC_IDX_CONFIG, 32'h4);
    wr(STC_IDX_ENABLE, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "fail irq");
    if (irq !== 1'b1) end_of_test();
    rdc(STC_IDX_INT_STAT, 32'h2, "fail event");
    chk({31'h0, calibration_complete}, 32'h0, "no complete");
    wr(STC_IDX_INT_CLR, 32'h2);
    rdc(STC_IDX_INT_STAT, 32'h0, "fail cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(STC_IDX_ENABLE, 32'h0);
  endtask : t_fail

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    half_period = 8'h01;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_manual();
    t_cal(2'h0, 2'h3);
    t_cal(2'h1, 2'h2);
    t_cal(2'h2, 2'h1);
    t_cal(2'h3, 2'h0);
    t_cal(2'h1, 2'h1);
    t_fail();
    end_of_test();
  end
endmodule : tb_sysref_timing_calibration
